// ===== tadc_i2c_slave.sv
// Serial slave, command decoder and converter control of the digitizer.
// Assumes link_clk oversamples SCL/SDA at least about 16 times per bit,
// and a converter that answers conv_start with one conv_done pulse.
`default_nettype none

// Operation
// - Match top five address bits to type code
// - Next two address bits from strap pins
// - Eighth address bit one reads, zero writes
// - Acknowledge a matching address byte on SDA
// - SDA falling while SCL high is START
// - SDA rising while SCL high is STOP
// - SDA moves only while SCL is low
// - Acknowledge held low over ninth clock high
// - Release SDA after master declines acknowledge
// - STOP or repeated START ends a transfer
// - Acknowledge address and accepted data bytes
// - Shift read data out on master clock
// - Works at standard, fast, high-speed rates
// - Channel bits set multiplexer and function
// - Power bits choose state after command
// - Reference power latched at transfer end
// - Driver-hold bit keeps drivers after conversion
// - Resolution bit: zero 12-bit, one 8-bit
// - Reference power separate from converter power
// - Top select bit picks differential touch modes
// - Refuse extra command bytes in one write
// - Read sends high byte, low byte, repeats
// - Acquire from select latch to transfer end
module tadc_i2c_slave
  import tadc_pkg::*;
#(
  // Arbitrary neutral device type code
  parameter logic [4:0] DEV_TYPE_ID = 5'h0B
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  input  wire logic [1:0]  address_strap_pins,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  output var  logic [3:0]  adc_channel,
  output var  logic        acquire,
  output var  logic        conv_start,
  output var  logic        converting,
  output var  logic        res_8bit,
  output var  logic        ref_power_on,
  output var  logic        adc_power_on,
  output var  logic        pen_touch_interrupt_en,
  output var  logic        x_drivers_on,
  output var  logic        y_drivers_on
);

  // ********************************
  // Decode functions
  // ********************************
  function automatic logic is_measure(input logic [3:0] c);
    logic r;
    r = c[3] ? c[2] : (c[1:0] != 2'h3);
    return r;
  endfunction : is_measure

  function automatic tadc_drv_t drv_decode(input logic [3:0] c);
    tadc_drv_t d;
    d = '0;
    if (c[3])
    begin
      case (c[1:0])
        2'h0:    d = '{x_on: 1'b1, y_on: 1'b0};
        2'h1:    d = '{x_on: 1'b0, y_on: 1'b1};
        2'h2:    d = '{x_on: 1'b1, y_on: 1'b1};
        default: d = '{x_on: c[2], y_on: c[2]};
      endcase
    end
    return d;
  endfunction : drv_decode

  // ********************************
  // Link domain: reset and pin sync
  // ********************************
  logic        lrst_s1_ff, lrst_n_ff;
  logic [1:0]  pin_s1_ff, pin_s2_ff, pin_q_ff;

  always_ff @(posedge link_clk)
  begin
    lrst_s1_ff <= rst_n;
    lrst_n_ff  <= lrst_s1_ff;
  end

  // Slot 1 is SCL, slot 0 is SDA
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_ff)
    begin
      pin_s1_ff <= 2'h3;
      pin_s2_ff <= 2'h3;
      pin_q_ff  <= 2'h3;
    end
    else
    begin
      pin_s1_ff <= {scl_i, sda_i};
      pin_s2_ff <= pin_s1_ff;
      pin_q_ff  <= pin_s2_ff;
    end
  end

  logic scl_s, sda_s, scl_q, sda_q;
  logic start_det, stop_det, scl_rise, scl_fall;
  assign scl_s = pin_s2_ff[1];
  assign sda_s = pin_s2_ff[0];
  assign scl_q = pin_q_ff[1];
  assign sda_q = pin_q_ff[0];
  // SDA moving with SCL high is a condition, never data
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;

  // ********************************
  // Link domain: protocol engine
  // ********************************
  tadc_state_t state_ff;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  sh_ff;
  logic [7:0]  tx_ff;
  logic        rw_ff, first_ff, cmd_got_ff, mack_ff, lo_sel_ff;
  logic [3:0]  chan_hold_ff;
  tadc_cmd_t   cmd_hold_ff;
  logic [1:0]  ltgl_ff;
  logic [11:0] lres_ff;
  logic [2:0]  rtg_s_ff;
  logic        addr_hit;
  logic        hold_ff, res_tgl_ff;
  logic [11:0] res_ff;

  // Address byte complete once eight bits are in sh_ff
  assign addr_hit =
    (sh_ff[`TADC_ID_MSB:`TADC_ID_LSB] == DEV_TYPE_ID) &&
    (sh_ff[`TADC_STRAP_MSB:`TADC_STRAP_LSB]
       == address_strap_pins);

  // Result word taken over when the system side toggles
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_ff)
    begin
      rtg_s_ff <= 3'h0;
      lres_ff  <= `TADC_RST_RES;
    end
    else
    begin
      rtg_s_ff <= {rtg_s_ff[1:0], res_tgl_ff};
      if (rtg_s_ff[2] ^ rtg_s_ff[1])
        lres_ff <= res_ff;
    end
  end

  // Straps are static board ties, read without sync
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_ff)
    begin
      state_ff     <= TADC_IDLE;
      bit_cnt_ff   <= `TADC_CNT_ZERO;
      sh_ff        <= `TADC_RST_BYTE;
      tx_ff        <= `TADC_RST_BYTE;
      rw_ff        <= 1'b0;
      first_ff     <= 1'b0;
      cmd_got_ff   <= 1'b0;
      mack_ff      <= 1'b0;
      lo_sel_ff    <= 1'b0;
      chan_hold_ff <= `TADC_RST_CHAN;
      cmd_hold_ff  <= '0;
      ltgl_ff      <= `TADC_RST_TGL;
      sda_oe       <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      // Repeated START keeps the bus; both end a command
      state_ff   <= start_det ? TADC_ADDR : TADC_IDLE;
      bit_cnt_ff <= `TADC_CNT_ZERO;
      sda_oe     <= 1'b0;
      cmd_got_ff <= 1'b0;
      if (cmd_got_ff)
        ltgl_ff[1] <= ~ltgl_ff[1];
    end
    else
    begin
      case (state_ff)
        TADC_ADDR:
        begin
          if (scl_rise)
          begin
            sh_ff      <= {sh_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + `TADC_CNT_ONE;
          end
          else if (scl_fall && bit_cnt_ff == `TADC_CNT_BYTE)
          begin
            rw_ff      <= sh_ff[`TADC_RW_BIT];
            first_ff   <= 1'b1;
            lo_sel_ff  <= 1'b0;
            state_ff   <= addr_hit ? TADC_ACK : TADC_SKIP;
            sda_oe     <= addr_hit;
            bit_cnt_ff <= `TADC_CNT_ZERO;
          end
        end
        TADC_ACK:
        begin
          // Held low across the whole ninth clock high
          if (scl_fall)
          begin
            bit_cnt_ff <= `TADC_CNT_ZERO;
            if (rw_ff && first_ff)
            begin
              tx_ff    <= lres_ff[`TADC_RES_HI_MSB:`TADC_RES_HI_LSB];
              sda_oe   <= ~lres_ff[`TADC_RES_HI_MSB];
              state_ff <= TADC_TX;
            end
            else
            begin
              sda_oe   <= 1'b0;
              state_ff <= TADC_RX;
            end
          end
        end
        TADC_RX:
        begin
          if (scl_rise)
          begin
            sh_ff      <= {sh_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + `TADC_CNT_ONE;
            if (first_ff && bit_cnt_ff == `TADC_CNT_SEL - `TADC_CNT_ONE)
              chan_hold_ff <= {sh_ff[2:0], sda_s};
          end
          else if (scl_fall && first_ff && bit_cnt_ff == `TADC_CNT_SEL)
            ltgl_ff[0] <= ~ltgl_ff[0];
          else if (scl_fall && bit_cnt_ff == `TADC_CNT_BYTE)
          begin
            bit_cnt_ff <= `TADC_CNT_ZERO;
            if (first_ff)
            begin
              cmd_hold_ff <= sh_ff;
              cmd_got_ff  <= 1'b1;
              first_ff    <= 1'b0;
              sda_oe      <= 1'b1;
              state_ff    <= TADC_ACK;
            end
            else
              state_ff <= TADC_SKIP;
          end
        end
        TADC_TX:
        begin
          // Next bit set up just after SCL falls
          if (scl_fall)
          begin
            if (bit_cnt_ff == `TADC_CNT_TXLAST)
            begin
              sda_oe     <= 1'b0;
              bit_cnt_ff <= `TADC_CNT_ZERO;
              state_ff   <= TADC_TXACK;
            end
            else
            begin
              tx_ff      <= {tx_ff[6:0], 1'b0};
              sda_oe     <= ~tx_ff[6];
              bit_cnt_ff <= bit_cnt_ff + `TADC_CNT_ONE;
            end
          end
        end
        TADC_TXACK:
        begin
          if (scl_rise)
            mack_ff <= ~sda_s;
          else if (scl_fall)
          begin
            if (mack_ff)
            begin
              lo_sel_ff <= ~lo_sel_ff;
              state_ff  <= TADC_TX;
              if (lo_sel_ff)
              begin
                tx_ff  <= lres_ff[`TADC_RES_HI_MSB:`TADC_RES_HI_LSB];
                sda_oe <= ~lres_ff[`TADC_RES_HI_MSB];
              end
              else
              begin
                tx_ff  <= {lres_ff[`TADC_RES_LO_MSB:`TADC_RES_LO_LSB],
                           `TADC_PAD_ZERO};
                sda_oe <= ~lres_ff[`TADC_RES_LO_MSB];
              end
            end
            else
            begin
              sda_oe   <= 1'b0;
              state_ff <= TADC_SKIP;
            end
          end
        end
        default:
          sda_oe <= 1'b0;
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge link_clk)
  begin
    sda_o <= 1'b0;
  end

  // ********************************
  // System domain: event crossing
  // ********************************
  logic [1:0] tg_s1_ff, tg_s2_ff, tg_s3_ff;
  logic       acq_ev, end_ev;
  tadc_cmd_t  cmd_cur;
  tadc_drv_t  drv_sel;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tg_s1_ff <= `TADC_RST_TGL;
      tg_s2_ff <= `TADC_RST_TGL;
      tg_s3_ff <= `TADC_RST_TGL;
    end
    else
    begin
      tg_s1_ff <= ltgl_ff;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
    end
  end

  // Held words are quiet for two cycles before the toggle lands
  assign acq_ev  = tg_s2_ff[0] ^ tg_s3_ff[0];
  assign end_ev  = tg_s2_ff[1] ^ tg_s3_ff[1];
  assign cmd_cur = cmd_hold_ff;
  assign drv_sel = drv_decode(chan_hold_ff);

  // ********************************
  // System domain: conversion control
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      adc_channel <= `TADC_RST_CHAN;
      acquire     <= 1'b0;
      conv_start  <= 1'b0;
      converting  <= 1'b0;
      x_drivers_on <= 1'b0;
      y_drivers_on <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      if (acq_ev)
      begin
        adc_channel  <= chan_hold_ff;
        acquire      <= 1'b1;
        x_drivers_on <= drv_sel.x_on;
        y_drivers_on <= drv_sel.y_on;
      end
      else if (end_ev && acquire)
      begin
        acquire <= 1'b0;
        if (is_measure(adc_channel))
        begin
          conv_start <= 1'b1;
          converting <= 1'b1;
        end
      end
      else if (conv_done && converting)
      begin
        converting <= 1'b0;
        if (!hold_ff)
        begin
          x_drivers_on <= 1'b0;
          y_drivers_on <= 1'b0;
        end
      end
    end
  end

  // ********************************
  // System domain: power and mode
  // ********************************
  // Power-up state is the lowest power one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ref_power_on           <= 1'b0;
      hold_ff                <= 1'b0;
      res_8bit               <= 1'b0;
      pen_touch_interrupt_en <= 1'b1;
    end
    else if (end_ev)
    begin
      ref_power_on <= cmd_cur.reference_keep_bit;
      hold_ff      <= cmd_cur.driver_hold_bit;
      res_8bit     <= cmd_cur.res_8bit;
      pen_touch_interrupt_en <= ~cmd_cur.driver_hold_bit;
    end
  end

  // Converter on while busy, or kept on by the hold bit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      adc_power_on <= 1'b0;
    else
      adc_power_on <= hold_ff | acquire | converting |
                      acq_ev;
  end

  // ********************************
  // System domain: result capture
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      res_ff     <= `TADC_RST_RES;
      res_tgl_ff <= 1'b0;
    end
    else if (conv_done && converting)
    begin
      res_ff     <= conv_result;
      res_tgl_ff <= ~res_tgl_ff;
    end
  end

endmodule : tadc_i2c_slave
`default_nettype wire

// ===== tadc_map.svh
// Constants for the touch digitizer serial slave and command decoder.
// Assumes inclusion by its bare name from the package only; the top module uses its macros.
`ifndef TADC_MAP_SVH
`define TADC_MAP_SVH

// ********************************
// Address byte layout
// ********************************
`define TADC_ID_MSB      7
`define TADC_ID_LSB      3
`define TADC_STRAP_MSB   2
`define TADC_STRAP_LSB   1
`define TADC_RW_BIT      0

// ********************************
// Bit counts
// ********************************
`define TADC_CNT_ZERO    4'h0
`define TADC_CNT_ONE     4'h1
`define TADC_CNT_SEL     4'h4
`define TADC_CNT_TXLAST  4'h7
`define TADC_CNT_BYTE    4'h8

// ********************************
// Result layout on the wire
// ********************************
`define TADC_RES_HI_MSB  11
`define TADC_RES_HI_LSB  4
`define TADC_RES_LO_MSB  3
`define TADC_RES_LO_LSB  0
`define TADC_PAD_ZERO    4'h0

// ********************************
// Reset values
// ********************************
`define TADC_RST_BYTE    8'h00
`define TADC_RST_RES     12'h000
`define TADC_RST_CHAN    4'h0
`define TADC_RST_TGL     2'h0

`endif

// ===== tadc_pkg.sv
// Types shared by the touch digitizer serial slave.
// Assumes tadc_map.svh sits in the same folder.
`default_nettype none
package tadc_pkg;
  `include "tadc_map.svh"

  // Command byte fields in wire order, MSB first
  typedef struct packed {
    logic [3:0] channel_select_bits;
    logic       reference_keep_bit;
    logic       driver_hold_bit;
    logic       res_8bit;
    logic       dont_care;
  } tadc_cmd_t;

  // Touch screen driver pair
  typedef struct packed {
    logic x_on;
    logic y_on;
  } tadc_drv_t;

  typedef enum logic [2:0] {
    TADC_IDLE  = 3'b000,
    TADC_ADDR  = 3'b001,
    TADC_ACK   = 3'b010,
    TADC_RX    = 3'b011,
    TADC_TX    = 3'b100,
    TADC_TXACK = 3'b101,
    TADC_SKIP  = 3'b110
  } tadc_state_t;
endpackage : tadc_pkg
`default_nettype wire

// ===== tadc_i2c_monitor.sv
// Concurrent checks on the ports of the digitizer serial slave.
// Assumes binding onto tadc_i2c_slave; link checks run on link_clk.
`default_nettype none
module tadc_i2c_monitor
  import tadc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       link_clk,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       conv_done,
  input wire logic [3:0] adc_channel,
  input wire logic       acquire,
  input wire logic       conv_start,
  input wire logic       converting,
  input wire logic       adc_power_on,
  input wire logic       x_drivers_on,
  input wire logic       y_drivers_on
);
  // ********************************
  // Link side
  // ********************************
  oe_move_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    $changed(sda_oe) |-> !scl_i) else $error("sda_oe moved with scl high");
  pull_only_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    sda_oe |-> sda_o == 1'b0) else $error("sda driven high");
  // ********************************
  // Converter side
  // ********************************
  start_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    conv_start |=> !conv_start && converting) else $error("conv_start");
  conv_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    converting && !conv_done |=> converting) else $error("converting");
  acq_conv_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    converting |-> !acquire) else $error("acquire during conversion");
  adc_pwr_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    acquire || converting |-> ##[0:2] adc_power_on)
    else $error("converter unpowered");
  se_nodrv_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    acquire && !adc_channel[3] |-> !x_drivers_on && !y_drivers_on)
    else $error("drivers on for single ended code");
  meas_only_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    conv_start |->
      !(adc_channel inside {4'h3, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB}))
    else $error("conversion for non measuring code");
endmodule : tadc_i2c_monitor

bind tadc_i2c_slave tadc_i2c_monitor u_mon (
  .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .conv_done(conv_done),
  .adc_channel(adc_channel), .acquire(acquire), .conv_start(conv_start),
  .converting(converting), .adc_power_on(adc_power_on),
  .x_drivers_on(x_drivers_on), .y_drivers_on(y_drivers_on)
);
`default_nettype wire

// ===== tadc_i2c_master.sv
// Behavioural serial bus master facing the digitizer slave.
// Assumes the bench resolves the wire with the slave's pull-down.
`default_nettype none
module tadc_i2c_master (
  output var  logic scl_out,
  output var  logic sda_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter bit; keeps oversampling well above sixteen
  localparam int Q = 120;
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // ********************************
  // Conditions
  // ********************************
  task automatic start_c();
    sda_out = 1'b1; #Q;
    scl_out = 1'b1; #Q;
    sda_out = 1'b0; #Q;
    scl_out = 1'b0; #Q;
  endtask : start_c
  task automatic stop_c();
    sda_out = 1'b0; #Q;
    scl_out = 1'b1; #Q;
    sda_out = 1'b1; #Q;
  endtask : stop_c
  // ********************************
  // Bits and bytes
  // ********************************
  // Data moves only with scl low
  task automatic xbit(input logic b, output logic r);
    sda_out = b; #Q;
    scl_out = 1'b1; #Q;
    r = sda_in; #Q;
    scl_out = 1'b0; #Q;
  endtask : xbit
  // ackb is the master's ninth bit: 1 when writing or declining
  task automatic xbyte(input logic [7:0] d, input logic ackb,
                       output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r[i]);
    xbit(ackb, ack);
  endtask : xbyte
endmodule : tadc_i2c_master
`default_nettype wire

// ===== tadc_tb.sv
// Self-checking bench for the digitizer serial slave.
// Assumes tadc_i2c_master as bus partner and a converter model here.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tadc_pkg::*;
  logic        clk, rst_n, link_clk, conv_done;
  logic [3:0]  cdly;
  logic        scl, sda_m, sda_o, sda_oe, acquire, conv_start, converting;
  logic        res_8bit, ref_power_on, adc_power_on, pen_en, x_on, y_on;
  logic [3:0]  adc_channel;
  logic [7:0]  r;
  logic        a;
  wire  logic  sda_w = sda_m & ~sda_oe;
  int          miscompares, checks_done;
  tadc_i2c_slave #(.DEV_TYPE_ID(5'h0B)) DUT (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_strap_pins(2'h2), .conv_done(conv_done),
    .conv_result(12'hABC), .adc_channel(adc_channel), .acquire(acquire),
    .conv_start(conv_start), .converting(converting), .res_8bit(res_8bit),
    .ref_power_on(ref_power_on), .adc_power_on(adc_power_on),
    .pen_touch_interrupt_en(pen_en), .x_drivers_on(x_on), .y_drivers_on(y_on));
  tadc_i2c_master m (.scl_out(scl), .sda_out(sda_m), .sda_in(sda_w));
  // ********************************
  // Clocks and converter
  // ********************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // Converter answers ten cycles after a start
  always @(negedge clk)
  begin
    conv_done <= (cdly == 4'h1);
    if (conv_start)
      cdly <= 4'hA;
    else if (cdly != 4'h0)
      cdly <= cdly - 4'h1;
  end
  // ********************************
  // Helpers
  // ********************************
  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wait_conv();
    int n;
    n = 0;
    while (conv_done !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      miscompares++;
      $display("Error conv_done expected 1 seen timeout");
      tally_and_finish();
    end
    repeat (3) @(negedge clk);
  endtask : wait_conv
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_bad_addr();
    logic [7:0] bad [3];
    bad = '{8'h5A, 8'h9C, 8'h08};
    foreach (bad[i])
    begin
      m.start_c();
      m.xbyte(bad[i], 1'b1, r, a);
      chk("foreign address ack", 12'h1, a);
      m.stop_c();
    end
    $display("t_bad_addr done");
  endtask : t_bad_addr
  task automatic t_write();
    m.start_c();
    m.xbyte(8'h5C, 1'b1, r, a);
    chk("write address ack", 12'h0, a);
    m.xbyte(8'hCA, 1'b1, r, a);
    chk("command ack", 12'h0, a);
    repeat (6) @(negedge clk);
    chk("adc_channel", 12'hC, adc_channel);
    chk("acquire", 12'h1, acquire);
    chk("drivers x y", 12'h2, {x_on, y_on});
    m.xbyte(8'h00, 1'b1, r, a);
    chk("extra byte ack", 12'h1, a);
    m.stop_c();
    wait_conv();
    chk("ref_power_on", 12'h1, ref_power_on);
    chk("res_8bit", 12'h1, res_8bit);
    chk("pen enable", 12'h1, pen_en);
    chk("drivers after", 12'h0, {x_on, y_on});
    $display("t_write done");
  endtask : t_write
  task automatic t_read();
    m.start_c();
    m.xbyte(8'h5D, 1'b1, r, a);
    chk("read address ack", 12'h0, a);
    for (int i = 0; i < 3; i++)
    begin
      m.xbyte(8'hFF, i == 2, r, a);
      chk("read byte", (i % 2) ? 12'h0C0 : 12'h0AB, r);
    end
    repeat (2) @(negedge clk);
    chk("release after nack", 12'h0, sda_oe);
    m.stop_c();
    $display("t_read done");
  endtask : t_read
  task automatic t_rstart();
    m.start_c();
    m.xbyte(8'h5C, 1'b1, r, a);
    m.xbyte(8'h06, 1'b1, r, a);
    chk("command ack", 12'h0, a);
    m.start_c();
    // Conversion runs while the master holds SCL low
    wait_conv();
    m.xbyte(8'h5C, 1'b1, r, a);
    chk("address after repeated start", 12'h0, a);
    m.stop_c();
    chk("ref off", 12'h0, ref_power_on);
    chk("pen disable", 12'h0, pen_en);
    chk("adc_channel", 12'h0, adc_channel);
    $display("t_rstart done");
  endtask : t_rstart
  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    #5000000;
    miscompares++;
    $display("Error run expected end seen timeout");
    tally_and_finish();
  end
  initial
  begin
    rst_n = 1'b0;
    cdly = 4'h0;
    miscompares = 0;
    checks_done = 0;
    repeat (6) @(negedge clk);
    chk("pen enable at reset", 12'h1, pen_en);
    chk("sda_oe at reset", 12'h0, sda_oe);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_bad_addr();
    t_write();
    t_read();
    t_rstart();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
